// >>> rtl/sid_params.svh
// Constants for the bit-serial integrator datapath
//
// How it works
// - Y carry sets when clear, Y bit one, dy register and step all true.
// - Y carry clears on carry with zero Y and dy, except at last data slot.
// - At last data slot the Y end carry is suppressed unless both bits overflow.
// - New Y sum one at final slot under run gate flags overflow and halts.
// - New Y bit is written back under run gate; true and inverse go to gating.
// - Gating passes new Y for positive dx, its inverse for negative dx.
// - Servo flop sets on dx with new Y and step, holds until step falls.
// - R adder sum is written back under run gate; last-slot carry is increment.
// - R carry sets on first-bit marker before step for negative dx.
// - R carry sets when R and gated increment are both one, except last slot.
// - R carry clears unconditionally at the last data slot of every word.
// - R carry clears during step when R and gated increment are both zero.
// - R end carry makes the increment and never raises the halting overflow.
// - Increment held in exist and sign flops, also sent out unmultiplied.
// - Increment flops show the result one word after its computation began.
// - Scaled increment is K, inverted K, or zero; true and inverse forms out.
// - r adds scaled increment; end carry sets output exist; sum written back.
// - z carry sets at once for a negative increment, forming twos complement.
// - z carry clears for positive or absent increment and on zero bits at end.
// - dy bit is dy register output gated by step; Y circulates on its line.
// - dx sign and exist flops supply a plus or minus one dx per word.
`ifndef SID_PARAMS_SVH
`define SID_PARAMS_SVH

// ****************************************
// Bit timing
// ****************************************
`define SID_CLK_NS       4
`define SID_BIT_TIME_NS  32
`define SID_BIT_CYCLES   (`SID_BIT_TIME_NS / `SID_CLK_NS)

// ****************************************
// APB map
// ****************************************
`define SID_CTRL_ADDR    12'h000
`define SID_STATUS_ADDR  12'h004
`define SID_CTRL_RUN     0
`define SID_STAT_HALT    0
`define SID_STAT_DZE     1
`define SID_STAT_DZS     2
`define SID_STAT_OUTE    3
`define SID_STAT_SERVO   4
`define SID_CTRL_RST     1'b0

`endif

// >>> rtl/sid_pkg.sv
// Types shared by the integrator datapath
`default_nettype none
package sid_pkg;

  // Drum and control lines as they arrive from the host
  typedef struct packed {
    logic y_bit;
    logic big_r_bit;
    logic small_r_bit;
    logic k_bit;
    logic first_bit_marker_line;
    logic bit_slot_last_data;
    logic bit_slot_final;
    logic run_gate;
    logic dy_out_ff;
    logic compute_step_ff;
    logic dx_exist_ff;
    logic dx_sign_ff;
  } sid_drum_in_s;

  // Bits written back to the drum lines, with the write gate
  typedef struct packed {
    logic y_bit;
    logic big_r_bit;
    logic small_r_bit;
    logic write_en;
  } sid_drum_out_s;

  // Integrator increment
  typedef struct packed {
    logic exist;
    logic sign;
  } sid_incr_s;

endpackage : sid_pkg
`default_nettype wire

// >>> rtl/sid_datapath.sv
// Bit-serial integrator datapath with APB status and control
//
// Decided for this implementation: the placing of the registers and register access over APB.
`include "sid_params.svh"
`default_nettype none
module sid_datapath
  import sid_pkg::*;
#(
  parameter int BIT_CYCLES = `SID_BIT_CYCLES
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire sid_drum_in_s drum_in,
  output sid_drum_out_s     drum_out,
  output logic              bit_tick,
  output logic              y_new_sum,
  output logic              y_new_sum_n,
  output logic              gated_increment,
  output logic              servo_enable_ff,
  output sid_incr_s         dz_ff,
  output logic              dz_strobe,
  output logic              scaled_dz,
  output logic              scaled_dz_n,
  output logic              output_exist_ff,
  output logic              overflow_pulse,
  output logic              halted
);

  // ****************************************
  // Input synchroniser
  // ****************************************
  sid_drum_in_s sync1_reg;
  sid_drum_in_s sync2_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= drum_in;
      sync2_reg <= sync1_reg;
    end
  end

  // ****************************************
  // Bit time divider
  // ****************************************
  // One enable pulse per drum bit time; the host presents one
  // bit of every line per such period.
  logic [15:0] div_reg;
  logic [15:0] div_next;
  logic        tick;

  assign tick     = (div_reg == 16'(BIT_CYCLES - 1));
  assign div_next = tick ? 16'h0000 : div_reg + 16'h0001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg  <= 16'h0000;
      bit_tick <= 1'b0;
    end else begin
      div_reg  <= div_next;
      bit_tick <= tick;
    end
  end

  // ****************************************
  // Control and status registers
  // ****************************************
  logic run_en_reg;
  logic halt_reg;

  wire  d_y     = sync2_reg.y_bit;
  wire  d_bigr  = sync2_reg.big_r_bit;
  wire  d_smr   = sync2_reg.small_r_bit;
  wire  d_k     = sync2_reg.k_bit;
  wire  d_first = sync2_reg.first_bit_marker_line;
  wire  d_last  = sync2_reg.bit_slot_last_data;
  wire  d_final = sync2_reg.bit_slot_final;
  wire  d_step  = sync2_reg.compute_step_ff;
  wire  d_dxe   = sync2_reg.dx_exist_ff;
  wire  d_dxs   = sync2_reg.dx_sign_ff;

  // Halt freezes every adder until software clears it
  wire  go      = sync2_reg.run_gate & run_en_reg & ~halt_reg;
  wire  step_en = tick & go;

  // ****************************************
  // Y plus dy adder
  // ****************************************
  logic y_carry_ff;

  wire dy_bit   = sync2_reg.dy_out_ff & d_step;
  wire yn_comb  = d_y ^ dy_bit ^ y_carry_ff;
  wire yc_set   = ~y_carry_ff & d_y & dy_bit;
  // Outside the last slot a carry meeting two zeros is spent
  wire yc_clr_n = ~d_last & y_carry_ff & ~d_y & ~dy_bit;
  // At the last slot only a real overflow of both bits survives
  wire yc_clr_l = d_last & ~(d_y & dy_bit);
  wire yc_next  = yc_set | (y_carry_ff & ~yc_clr_n & ~yc_clr_l);
  wire ovf_hit  = yn_comb & d_final & go;

  // ****************************************
  // Gating by dx
  // ****************************************
  // Negative dx takes the ones complement; the low-order one is
  // injected into the R carry at the first bit.
  wire gi_comb  = d_step & d_dxe & (d_dxs ? ~yn_comb : yn_comb);
  wire se_next  = ~d_step ? 1'b0 :
                  (servo_enable_ff | (d_dxe & yn_comb));

  // ****************************************
  // R plus gated increment adder
  // ****************************************
  // R holds a positive remainder preloaded with one half by
  // software, so no sign handling is needed here.
  logic r_carry_ff;
  logic r_end_carry_reg;
  logic r_end_sign_reg;

  wire rn_comb   = d_bigr ^ gi_comb ^ r_carry_ff;
  wire rc_cout   = (d_bigr & gi_comb) | (r_carry_ff & (d_bigr | gi_comb));
  wire rc_set_tc = d_dxe & d_dxs & ~d_step & d_first;
  wire rc_set_ad = ~d_last & d_bigr & gi_comb;
  wire rc_clr    = d_step & ~d_bigr & ~gi_comb;
  wire rc_hold   = (rc_set_tc | rc_set_ad | (r_carry_ff & ~rc_clr));
  wire rc_next   = ~d_last & rc_hold;

  // ****************************************
  // Increment and scaling by K
  // ****************************************
  logic z_carry_ff;

  wire sdz_comb  = dz_ff.exist & (dz_ff.sign ? ~d_k : d_k);
  wire srn_comb  = d_smr ^ sdz_comb ^ z_carry_ff;
  wire zc_cout   = (d_smr & sdz_comb) | (z_carry_ff & (d_smr | sdz_comb));
  // Increment that will be committed at the end of this word
  wire inc_exist = r_end_carry_reg | servo_enable_ff;
  wire inc_sign  = r_end_sign_reg;
  wire zc_end0   = d_last & go & ~d_smr & ~sdz_comb;
  wire zc_norm   = ~d_last & (zc_cout | (z_carry_ff & sdz_comb & d_smr));
  wire zc_next   = d_final ? (inc_exist & inc_sign) :
                   (zc_end0 ? 1'b0 : zc_norm);

  // ****************************************
  // Serial state
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      y_carry_ff      <= 1'b0;
      servo_enable_ff <= 1'b0;
      r_carry_ff      <= 1'b0;
      z_carry_ff      <= 1'b0;
    end else if (step_en) begin
      y_carry_ff      <= yc_next;
      servo_enable_ff <= se_next;
      r_carry_ff      <= rc_next;
      z_carry_ff      <= zc_next;
    end
  end

  // End carry of R is captured at the last slot, not routed to halt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_end_carry_reg <= 1'b0;
      r_end_sign_reg  <= 1'b0;
    end else if (step_en && d_last) begin
      r_end_carry_reg <= rc_cout;
      r_end_sign_reg  <= gi_comb;
    end
  end

  // Increment flops change at the end of the word, so they are
  // read during the following word.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dz_ff     <= '0;
      dz_strobe <= 1'b0;
    end else begin
      dz_strobe <= step_en & d_final;
      if (step_en && d_final) begin
        dz_ff.exist <= inc_exist;
        dz_ff.sign  <= inc_exist & inc_sign;
      end
    end
  end

  // Output exist stands for one bit time after the last slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_exist_ff <= 1'b0;
    end else if (step_en) begin
      output_exist_ff <= d_last & zc_cout;
    end
  end

  // ****************************************
  // Drum write-back and serial outputs
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drum_out        <= '0;
      y_new_sum       <= 1'b0;
      y_new_sum_n     <= 1'b1;
      gated_increment <= 1'b0;
      scaled_dz       <= 1'b0;
      scaled_dz_n     <= 1'b1;
    end else if (tick) begin
      drum_out.write_en    <= go;
      drum_out.y_bit       <= yn_comb;
      drum_out.big_r_bit   <= rn_comb;
      drum_out.small_r_bit <= srn_comb;
      y_new_sum            <= yn_comb;
      y_new_sum_n          <= ~yn_comb;
      gated_increment      <= gi_comb;
      scaled_dz            <= sdz_comb;
      scaled_dz_n          <= ~sdz_comb;
    end
  end

  // ****************************************
  // Overflow and halt
  // ****************************************
  wire apb_setup = psel & ~penable;
  wire apb_acc   = psel & penable;
  wire hit_ctrl  = (paddr == `SID_CTRL_ADDR);
  wire hit_stat  = (paddr == `SID_STATUS_ADDR);
  wire wr_ctrl   = apb_acc & pwrite & hit_ctrl;
  wire wr_stat   = apb_acc & pwrite & hit_stat;
  wire halt_clr  = wr_stat & pwdata[`SID_STAT_HALT];
  wire ovf_set   = step_en & ovf_hit;

  // A new overflow in the clearing cycle keeps the flag set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_reg       <= 1'b0;
      overflow_pulse <= 1'b0;
    end else begin
      overflow_pulse <= ovf_set;
      halt_reg       <= ovf_set | (halt_reg & ~halt_clr);
    end
  end

  assign halted = halt_reg;

  // ****************************************
  // APB slave
  // ****************************************
  // Zero wait states; read data is sampled in the setup cycle.
  logic [31:0] rd_mux;
  logic [31:0] stat_word;

  assign stat_word = {27'h0, servo_enable_ff, output_exist_ff,
                      dz_ff.sign, dz_ff.exist, halt_reg};
  assign rd_mux    = hit_ctrl ? {31'h0, run_en_reg} :
                     hit_stat ? stat_word : 32'h00000000;
  assign pready    = 1'b1;
  assign pslverr   = apb_acc & ~hit_ctrl & ~hit_stat;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_en_reg <= `SID_CTRL_RST;
      prdata     <= 32'h00000000;
    end else begin
      if (wr_ctrl) begin
        run_en_reg <= pwdata[`SID_CTRL_RUN];
      end
      if (apb_setup && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

endmodule // sid_datapath
`default_nettype wire

// >>> verification/sid_datapath_props.sv
// Concurrent checks on the integrator datapath ports
`default_nettype none
module sid_datapath_props
  import sid_pkg::*;
#(
  parameter int BIT_CYCLES = 8
) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire sid_drum_in_s  drum_in,
  input wire sid_drum_out_s drum_out,
  input wire logic          bit_tick,
  input wire logic          y_new_sum,
  input wire logic          y_new_sum_n,
  input wire logic          gated_increment,
  input wire logic          servo_enable_ff,
  input wire sid_incr_s     dz_ff,
  input wire logic          dz_strobe,
  input wire logic          scaled_dz,
  input wire logic          scaled_dz_n,
  input wire logic          overflow_pulse,
  input wire logic          halted
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence next_tick;
    ##BIT_CYCLES bit_tick;
  endsequence
  tick_period_a: assert property (bit_tick |-> next_tick)
    else $error("bit tick spacing wrong");
  ysum_pair_a: assert property (y_new_sum_n != y_new_sum)
    else $error("new Y pair not complementary");
  kdz_pair_a: assert property (scaled_dz_n != scaled_dz)
    else $error("scaled pair not complementary");
  gate_sign_a: assert property (gated_increment |-> y_new_sum != drum_in.dx_sign_ff)
    else $error("gate ignores dx sign");
  gate_exist_a: assert property (gated_increment |-> drum_in.dx_exist_ff)
    else $error("gate open without dx");
  servo_cause_a: assert property ($rose(servo_enable_ff) |-> drum_in.dx_exist_ff)
    else $error("servo set without dx");
  halt_ovf_a: assert property (overflow_pulse |=> halted)
    else $error("overflow did not halt");
  halt_wen_a: assert property ($rose(halted) |-> ##[0:BIT_CYCLES] !drum_out.write_en)
    else $error("write gate open while halted");
  dz_commit_a: assert property ($changed(dz_ff) |-> dz_strobe)
    else $error("increment changed outside word end");
  dz_tick_a: assert property (dz_strobe |-> bit_tick)
    else $error("increment strobe off the bit tick");
  dz_sign_a: assert property (dz_ff.sign |-> dz_ff.exist)
    else $error("increment sign without existence");
endmodule // sid_datapath_props
bind sid_datapath sid_datapath_props #(.BIT_CYCLES(BIT_CYCLES)) u_props (
  .pclk(pclk), .presetn(presetn), .drum_in(drum_in), .drum_out(drum_out),
  .bit_tick(bit_tick), .y_new_sum(y_new_sum), .y_new_sum_n(y_new_sum_n),
  .gated_increment(gated_increment), .servo_enable_ff(servo_enable_ff),
  .dz_ff(dz_ff), .dz_strobe(dz_strobe),
  .scaled_dz(scaled_dz), .scaled_dz_n(scaled_dz_n),
  .overflow_pulse(overflow_pulse), .halted(halted));
`default_nettype wire

// >>> verification/sid_drum_model.sv
// Behavioural drum lines and word timing seen by the datapath
`default_nettype none
module sid_drum_model
  import sid_pkg::*;
#(
  parameter int WB = 6
) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          bit_tick,
  input wire sid_drum_out_s drum_out,
  output sid_drum_in_s      drum_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [WB-1:0] y_w = '0, br_w = '0, sr_w = '0, k_w = '0, dy_w = '0;
  logic          dxe = 1'b0, dxs = 1'b0, run;
  int            s, nw;
  // Slots run LSB first; the final slot doubles as the marker slot with step low,
  // so the twos complement carry is ready at bit zero of the next word
  assign drum_in = '{y_w[s], br_w[s], sr_w[s], k_w[s], s == WB-1, s == WB-2,
                     s == WB-1, run, dy_w[s], s != WB-1, dxe, dxs};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s   <= 0;
      run <= 1'b0;
    end else if (bit_tick) begin
      if (drum_out.write_en) begin
        y_w[s]  <= drum_out.y_bit;
        br_w[s] <= drum_out.big_r_bit;
        sr_w[s] <= drum_out.small_r_bit;
      end
      s <= (s == WB-1) ? 0 : s + 1;
      // Run opens one slot early so the marker of the leading slot is seen
      if (s == WB-2 && !run && nw > 0) run <= 1'b1;
      if (s == WB-1 && run) begin
        if (nw == 0) run <= 1'b0;
        else nw <= nw - 1;
      end
    end
  end
endmodule // sid_drum_model
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the integrator datapath
`default_nettype none
module tb_top
  import sid_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          pclk = 1'b0;
  logic          presetn = 1'b0;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [11:0]   paddr = 12'h000;
  logic [31:0]   pwdata = 32'h0;
  logic [31:0]   prdata, q;
  logic          pready, pslverr, bit_tick, oe_ff, ovf, halted, e;
  logic          oe_seen, ovf_seen;
  sid_incr_s     dz_ff, dz_w1;
  sid_drum_in_s  din;
  sid_drum_out_s dout;
  int            num_errors = 0, checked = 0, cyc = 0;
  always #2 pclk = ~pclk;
  sid_datapath #(.BIT_CYCLES(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .drum_in(din), .drum_out(dout),
    .bit_tick(bit_tick), .y_new_sum(), .y_new_sum_n(), .gated_increment(),
    .servo_enable_ff(), .dz_ff(dz_ff), .dz_strobe(), .scaled_dz(), .scaled_dz_n(),
    .output_exist_ff(oe_ff), .overflow_pulse(ovf), .halted(halted));
  sid_drum_model #(.WB(6)) mdl (.pclk(pclk), .presetn(presetn), .bit_tick(bit_tick),
    .drum_out(dout), .drum_in(din));
  always @(negedge pclk) begin
    if (ovf === 1'b1) ovf_seen = 1'b1;
    if (oe_ff === 1'b1) oe_seen = 1'b1;
    if (bit_tick && mdl.s == 0 && mdl.run && mdl.nw == 0) dz_w1 = dz_ff;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      $display("MISMATCH %0t timeout", $time);
      results();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic rst();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, 12'h000, 32'h1);
    oe_seen = 1'b0;
    ovf_seen = 1'b0;
  endtask
  task automatic load(input logic [5:0] y, dy, r, sr, k, input logic xe, xs);
    // Lines change only under reset, so no stale gated bit meets the new dx
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    mdl.y_w = y;
    mdl.dy_w = dy;
    mdl.br_w = r;
    mdl.sr_w = sr;
    mdl.k_w = k;
    mdl.dxe = xe;
    mdl.dxs = xs;
  endtask
  task automatic run_w(input int n);
    mdl.nw <= n;
    wait (mdl.run === 1'b1);
    wait (mdl.run === 1'b0);
    @(negedge pclk);
  endtask
  task automatic t_apb();
    apb(1'b0, 12'h004, 32'h0);
    chk(q === 32'h0 && e === 1'b0, "status reset value");
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk(q === 32'h0 && e === 1'b1, "unmapped access");
    apb(1'b0, 12'h000, 32'h0);
    chk(q === 32'h1, "control readback");
    $display("done apb");
  endtask
  task automatic t_pos();
    load(6'h07, 6'h01, 6'h1c, 6'h0c, 6'h15, 1'b1, 1'b0);
    rst();
    run_w(2);
    chk(mdl.y_w === 6'h09, "Y sum");
    chk(mdl.br_w[4:0] === 5'h0d, "R sum");
    chk(dz_w1 === 2'b10, "positive increment");
    chk(mdl.sr_w[4:0] === 5'h01 && oe_seen, "r sum with K");
    chk(halted === 1'b0, "R end carry halted");
    $display("done pos");
  endtask
  task automatic t_neg();
    load(6'h03, 6'h01, 6'h10, 6'h0c, 6'h05, 1'b1, 1'b1);
    rst();
    run_w(2);
    chk(mdl.y_w === 6'h05, "Y sum neg");
    chk(mdl.br_w[4:0] === 5'h07, "R twos complement");
    chk(dz_w1 === 2'b11 && dz_ff === 2'b11, "negative increment");
    chk(mdl.sr_w[4:0] === 5'h07 && oe_seen, "r minus K");
    apb(1'b0, 12'h004, 32'h0);
    chk(q[4:0] === 5'b00110, "status increment");
    $display("done neg");
  endtask
  task automatic t_ovf();
    load(6'h10, 6'h10, 6'h05, 6'h00, 6'h00, 1'b0, 1'b0);
    rst();
    run_w(1);
    chk(ovf_seen && halted === 1'b1, "Y overflow halt");
    chk(mdl.br_w[4:0] === 5'h05, "R kept without dx");
    apb(1'b0, 12'h004, 32'h0);
    chk(q[0] === 1'b1, "status halt");
    apb(1'b1, 12'h004, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    chk(q[0] === 1'b0 && halted === 1'b0, "halt cleared");
    $display("done ovf");
  endtask
  task automatic results();
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    rst();
    t_apb();
    t_pos();
    t_neg();
    t_ovf();
    results();
  end
endmodule // tb_top
`default_nettype wire
